// ==== include/integer_add_unit_map.svh ====
// register offsets, instruction fields and constants of the add unit
`ifndef INTEGER_ADD_UNIT_MAP_SVH
`define INTEGER_ADD_UNIT_MAP_SVH

// byte offsets on the register bus
`define IAU_OFS_FLAGS 4'h0
`define IAU_OFS_COND  4'h4
`define IAU_OFS_COUNT 4'h8
`define IAU_OFS_CTRL  4'hC

// flag and control register bit positions
`define IAU_FLG_CARRY 0
`define IAU_FLG_WRAP  1
`define IAU_FLG_SUMM  2
`define IAU_CTRL_EN   0

// condition field bit positions
`define IAU_CR_NEG  3
`define IAU_CR_POS  2
`define IAU_CR_ZERO 1
`define IAU_CR_SUMM 0

// instruction fields, bit 31 of the word being the msb
`define IAU_F_OPC  31:26
`define IAU_F_DST  25:21
`define IAU_F_SRCA 20:16
`define IAU_F_SRCB 15:11
`define IAU_F_OE   10
`define IAU_F_XO   9:1
`define IAU_F_RC   0
`define IAU_F_IMM  15:0

// primary and extended opcodes
`define IAU_PRI_REG           6'h1F
`define IAU_PRI_IMM_CARRY     6'h0C
`define IAU_PRI_IMM_CARRY_REC 6'h0D
`define IAU_PRI_IMM           6'h0E
`define IAU_PRI_IMM_HI        6'h0F
`define IAU_XO_SUM            9'h10A
`define IAU_XO_SUM_CARRY      9'h00A
`define IAU_XO_SUM_EXT        9'h08A
`define IAU_XO_SUM_M1         9'h0EA
`define IAU_XO_SUM_Z          9'h0CA

// constants and reset values
`define IAU_ZERO32   32'h0000_0000
`define IAU_ONES32   32'hFFFF_FFFF
`define IAU_ZERO16   16'h0000
`define IAU_ZERO_IDX 5'h00
`define IAU_CR_RST   4'h0
`define IAU_CNT_ONE  32'h0000_0001

`endif

// ==== include/iau_pkg.sv ====
// types shared by the add unit
package iau_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  typedef enum logic [9:0] {
    OP_NONE          = 10'h001,
    OP_SUM           = 10'h002,
    OP_SUM_CARRY     = 10'h004,
    OP_SUM_EXT       = 10'h008,
    OP_SUM_M1        = 10'h010,
    OP_SUM_Z         = 10'h020,
    OP_IMM           = 10'h040,
    OP_IMM_HI        = 10'h080,
    OP_IMM_CARRY     = 10'h100,
    OP_IMM_CARRY_REC = 10'h200
  } op_t;

endpackage : iau_pkg

// ==== src/add_core.sv ====
// carry-in adder with carry out and signed wrap detect
`timescale 1ns/1ps
module add_core #(
  parameter int WIDTH = 32
) (
  // operands
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire logic             carry_in,
  // results
  output logic      [WIDTH-1:0] sum,
  output logic                  carry_out,
  output logic                  wrap
);
  logic [WIDTH:0] full;

  assign full      = {1'b0, op_a} + {1'b0, op_b} + {{WIDTH{1'b0}}, carry_in};
  assign sum       = full[WIDTH-1:0];
  assign carry_out = full[WIDTH];
  // same-sign operands giving an opposite-sign result
  assign wrap      = (op_a[WIDTH-1] == op_b[WIDTH-1]) && (sum[WIDTH-1] != op_a[WIDTH-1]);
endmodule : add_core

// ==== src/integer_add_unit.sv ====
// integer add datapath with flag update and register bus slave
`timescale 1ns/1ps
`include "integer_add_unit_map.svh"
// Contract
// - plain register sum, carry untouched
// - carrying sum always updates carry
// - extended sum adds carry, updates carry
// - immediate sum, sign extended, no flags
// - source index zero means constant zero for the immediate and shifted immediate sums only
// - shifted immediate in upper half, no flags
// - carrying immediate updates carry only
// - recorded carrying immediate updates condition field
// - minus-one extended sum updates carry
// - zero extended sum updates carry
// - register forms record condition when selected
// - register forms record overflow when enabled
// - condition taken from truncated result
module integer_add_unit (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // issue from decoder and register file
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] src_a_data,
  input  wire logic [31:0] src_b_data,
  // write-back
  output logic             wb_valid,
  output logic [4:0]       wb_index,
  output logic [31:0]      wb_data,
  // flags
  output logic             carry_flag,
  output logic             signed_wrap_flag,
  output logic             summary_flag,
  output logic [3:0]       cond_field_zero,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  function automatic iau_pkg::op_t decode_op(input logic [31:0] w);
    iau_pkg::op_t r;
    r = iau_pkg::OP_NONE;
    case (w[`IAU_F_OPC])
      `IAU_PRI_REG: begin
        case (w[`IAU_F_XO])
          `IAU_XO_SUM:       r = iau_pkg::OP_SUM;
          `IAU_XO_SUM_CARRY: r = iau_pkg::OP_SUM_CARRY;
          `IAU_XO_SUM_EXT:   r = iau_pkg::OP_SUM_EXT;
          `IAU_XO_SUM_M1:    r = iau_pkg::OP_SUM_M1;
          `IAU_XO_SUM_Z:     r = iau_pkg::OP_SUM_Z;
          default:           r = iau_pkg::OP_NONE;
        endcase
      end
      `IAU_PRI_IMM:           r = iau_pkg::OP_IMM;
      `IAU_PRI_IMM_HI:        r = iau_pkg::OP_IMM_HI;
      `IAU_PRI_IMM_CARRY:     r = iau_pkg::OP_IMM_CARRY;
      `IAU_PRI_IMM_CARRY_REC: r = iau_pkg::OP_IMM_CARRY_REC;
      default:                r = iau_pkg::OP_NONE;
    endcase
    return r;
  endfunction : decode_op

  iau_pkg::op_t       op;
  iau_pkg::bus_state_t bus_q;
  logic [31:0] opnd_a;
  logic [31:0] opnd_b;
  logic        cin;
  logic [31:0] imm_sx;
  logic [31:0] sum;
  logic        cout;
  logic        wrap;
  logic        is_reg;
  logic        fire;
  logic        rec;
  logic        oe;
  logic        upd_carry;
  logic        new_summ;
  logic [3:0]  cr_d;
  logic        sw_wr;
  logic        sw_flags_wr;
  logic        sw_ctrl_wr;
  logic        carry_q;
  logic        wrap_q;
  logic        summ_q;
  logic [3:0]  cr_q;
  logic        enable_q;
  logic [31:0] count_q;
  logic        wb_valid_q;
  logic [4:0]  wb_index_q;
  logic [31:0] wb_data_q;
  logic [31:0] readdata_q;
  logic        waitreq_q;

  assign op     = decode_op(instr_word);
  assign imm_sx = {{16{instr_word[15]}}, instr_word[`IAU_F_IMM]};
  assign is_reg = (op == iau_pkg::OP_SUM) || (op == iau_pkg::OP_SUM_CARRY) ||
                  (op == iau_pkg::OP_SUM_EXT) || (op == iau_pkg::OP_SUM_M1) ||
                  (op == iau_pkg::OP_SUM_Z);
  assign fire   = instr_valid && enable_q && (op != iau_pkg::OP_NONE);
  assign rec    = is_reg ? instr_word[`IAU_F_RC]
                         : (op == iau_pkg::OP_IMM_CARRY_REC);
  assign oe     = is_reg && instr_word[`IAU_F_OE];
  // plain and immediate sums leave carry alone
  assign upd_carry = (op != iau_pkg::OP_SUM) && (op != iau_pkg::OP_IMM) &&
                     (op != iau_pkg::OP_IMM_HI) && (op != iau_pkg::OP_NONE);

  // operand selection
  always_comb begin
    opnd_a = src_a_data;
    opnd_b = src_b_data;
    cin    = 1'b0;
    case (op)
      iau_pkg::OP_SUM_EXT: cin = carry_q;
      iau_pkg::OP_SUM_M1: begin
        opnd_b = `IAU_ONES32;
        cin    = carry_q;
      end
      iau_pkg::OP_SUM_Z: begin
        opnd_b = `IAU_ZERO32;
        cin    = carry_q;
      end
      iau_pkg::OP_IMM: begin
        if (instr_word[`IAU_F_SRCA] == `IAU_ZERO_IDX) begin
          opnd_a = `IAU_ZERO32;
        end
        opnd_b = imm_sx;
      end
      iau_pkg::OP_IMM_HI: begin
        if (instr_word[`IAU_F_SRCA] == `IAU_ZERO_IDX) begin
          opnd_a = `IAU_ZERO32;
        end
        opnd_b = {instr_word[`IAU_F_IMM], `IAU_ZERO16};
      end
      iau_pkg::OP_IMM_CARRY, iau_pkg::OP_IMM_CARRY_REC: opnd_b = imm_sx;
      default: cin = 1'b0;
    endcase
  end

  add_core #(
    .WIDTH (32)
  ) u_add (
    .op_a      (opnd_a),
    .op_b      (opnd_b),
    .carry_in  (cin),
    .sum       (sum),
    .carry_out (cout),
    .wrap      (wrap)
  );

  // condition field from the truncated sum
  assign new_summ = summ_q || (oe && wrap);
  always_comb begin
    cr_d               = `IAU_CR_RST;
    cr_d[`IAU_CR_NEG]  = sum[31];
    cr_d[`IAU_CR_ZERO] = (sum == `IAU_ZERO32);
    cr_d[`IAU_CR_POS]  = !sum[31] && (sum != `IAU_ZERO32);
    cr_d[`IAU_CR_SUMM] = new_summ;
  end

  // bus slave: one wait cycle, then answer
  assign sw_wr       = (bus_q == iau_pkg::BUS_ACK) && avs_write && avs_byteenable[0];
  assign sw_flags_wr = sw_wr && (avs_address == `IAU_OFS_FLAGS);
  assign sw_ctrl_wr  = sw_wr && (avs_address == `IAU_OFS_CTRL);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_q     <= iau_pkg::BUS_IDLE;
      waitreq_q <= 1'b1;
    end else begin
      case (bus_q)
        iau_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q     <= iau_pkg::BUS_ACK;
            waitreq_q <= 1'b0;
          end
        end
        iau_pkg::BUS_ACK: begin
          bus_q     <= iau_pkg::BUS_IDLE;
          waitreq_q <= 1'b1;
        end
        default: begin
          bus_q     <= iau_pkg::BUS_IDLE;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      readdata_q <= `IAU_ZERO32;
    end else if (bus_q == iau_pkg::BUS_IDLE && avs_read) begin
      readdata_q <= `IAU_ZERO32;
      case (avs_address)
        `IAU_OFS_FLAGS: begin
          readdata_q[`IAU_FLG_CARRY] <= carry_q;
          readdata_q[`IAU_FLG_WRAP]  <= wrap_q;
          readdata_q[`IAU_FLG_SUMM]  <= summ_q;
        end
        `IAU_OFS_COND:  readdata_q[3:0] <= cr_q;
        `IAU_OFS_COUNT: readdata_q <= count_q;
        `IAU_OFS_CTRL:  readdata_q[`IAU_CTRL_EN] <= enable_q;
        default:        readdata_q <= `IAU_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b1;
    end else if (sw_ctrl_wr) begin
      enable_q <= avs_writedata[`IAU_CTRL_EN];
    end
  end

  // carry: the instruction wins over a software write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      carry_q <= 1'b0;
    end else if (fire && upd_carry) begin
      carry_q <= cout;
    end else if (sw_flags_wr) begin
      carry_q <= avs_writedata[`IAU_FLG_CARRY];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrap_q <= 1'b0;
    end else if (fire && oe) begin
      wrap_q <= wrap;
    end else if (sw_flags_wr) begin
      wrap_q <= avs_writedata[`IAU_FLG_WRAP];
    end
  end

  // summary: an overflow set beats a software clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      summ_q <= 1'b0;
    end else if (fire && oe && wrap) begin
      summ_q <= 1'b1;
    end else if (sw_flags_wr) begin
      summ_q <= avs_writedata[`IAU_FLG_SUMM];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cr_q <= `IAU_CR_RST;
    end else if (fire && rec) begin
      cr_q <= cr_d;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= `IAU_ZERO32;
    end else if (fire) begin
      count_q <= count_q + `IAU_CNT_ONE;
    end
  end

  // write-back, one cycle after issue
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_valid_q <= 1'b0;
      wb_index_q <= `IAU_ZERO_IDX;
      wb_data_q  <= `IAU_ZERO32;
    end else begin
      wb_valid_q <= fire;
      if (fire) begin
        wb_index_q <= instr_word[`IAU_F_DST];
        wb_data_q  <= sum;
      end
    end
  end

  assign wb_valid         = wb_valid_q;
  assign wb_index         = wb_index_q;
  assign wb_data          = wb_data_q;
  assign carry_flag       = carry_q;
  assign signed_wrap_flag = wrap_q;
  assign summary_flag     = summ_q;
  assign cond_field_zero  = cr_q;
  assign avs_readdata     = readdata_q;
  assign avs_waitrequest  = waitreq_q;

  // checking helpers
  logic [31:0] chk_ab;
  logic [32:0] chk_ab_wide;
  logic [31:0] chk_ext;
  logic [31:0] chk_m1;
  logic        chk_a_zero;
  assign chk_ab      = src_a_data + src_b_data;
  assign chk_ab_wide = {1'b0, src_a_data} + {1'b0, src_b_data};
  assign chk_ext     = src_a_data + src_b_data + {31'h0000_0000, carry_q};
  assign chk_m1      = src_a_data + `IAU_ONES32 + {31'h0000_0000, carry_q};
  assign chk_a_zero  = (instr_word[`IAU_F_SRCA] == `IAU_ZERO_IDX);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_sum_plain;
    fire && op == iau_pkg::OP_SUM && !sw_flags_wr
      |=> wb_valid && wb_data == $past(chk_ab) && carry_flag == $past(carry_q);
  endproperty
  a_sum_plain: assert property (p_sum_plain) else $error("plain sum wrong");

  property p_sum_carry;
    fire && op == iau_pkg::OP_SUM_CARRY |=> carry_flag == $past(chk_ab_wide[32]);
  endproperty
  a_sum_carry: assert property (p_sum_carry) else $error("carry not updated");

  property p_sum_ext;
    fire && op == iau_pkg::OP_SUM_EXT |=> wb_data == $past(chk_ext);
  endproperty
  a_sum_ext: assert property (p_sum_ext) else $error("extended sum wrong");

  property p_imm_zero;
    fire && op == iau_pkg::OP_IMM && chk_a_zero && !sw_flags_wr
      |=> wb_data == $past(imm_sx) && $stable(cond_field_zero) && $stable(carry_flag);
  endproperty
  a_imm_zero: assert property (p_imm_zero) else $error("immediate sum wrong");

  property p_imm_hi;
    fire && op == iau_pkg::OP_IMM_HI && chk_a_zero
      |=> wb_data == {$past(instr_word[`IAU_F_IMM]), `IAU_ZERO16};
  endproperty
  a_imm_hi: assert property (p_imm_hi) else $error("shifted immediate wrong");

  property p_imm_rec;
    fire && op == iau_pkg::OP_IMM_CARRY_REC |=> cond_field_zero == $past(cr_d);
  endproperty
  a_imm_rec: assert property (p_imm_rec) else $error("record not applied");

  property p_sum_m1;
    fire && op == iau_pkg::OP_SUM_M1 |=> wb_data == $past(chk_m1);
  endproperty
  a_sum_m1: assert property (p_sum_m1) else $error("minus-one sum wrong");

  property p_no_rec;
    fire && is_reg && !instr_word[`IAU_F_RC] |=> $stable(cond_field_zero);
  endproperty
  a_no_rec: assert property (p_no_rec) else $error("condition changed");

  property p_no_oe;
    fire && is_reg && !instr_word[`IAU_F_OE] && !sw_flags_wr
      |=> $stable(signed_wrap_flag) && $stable(summary_flag);
  endproperty
  a_no_oe: assert property (p_no_oe) else $error("overflow changed");

  property p_onehot;
    fire && rec |=> $onehot(cond_field_zero[3:1]);
  endproperty
  a_onehot: assert property (p_onehot) else $error("condition not one-hot");

  property p_summ_keep;
    $fell(summary_flag) |-> $past(sw_flags_wr);
  endproperty
  a_summ_keep: assert property (p_summ_keep) else $error("summary cleared");

  property p_bus_ack;
    bus_q == iau_pkg::BUS_IDLE && (avs_read || avs_write)
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

  c_ovf_rec: cover property (fire && oe && wrap && rec);
  c_ext_chain: cover property (fire && op == iau_pkg::OP_SUM_CARRY
                               ##1 fire && op == iau_pkg::OP_SUM_EXT);
  c_bus_write: cover property (sw_flags_wr);
endmodule : integer_add_unit

// ==== verification/gpr_file_model.sv ====
// general register file model feeding the add unit
`timescale 1ns/1ps
module gpr_file_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // issue side
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  // write-back
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_index,
  input  wire logic [31:0] wb_data,
  // operands
  output logic      [31:0] src_a_data,
  output logic      [31:0] src_b_data
);
  logic [31:0] regs_q [32];
  logic [31:0] last_a_q;
  logic [31:0] last_b_q;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) regs_q[i] <= 32'h0000_0000;
    end else if (wb_valid) begin
      regs_q[wb_index] <= wb_data;
    end
  end

  // operands idle as the inverse of the last value, never a stale copy
  always @(posedge clk_sys) begin
    last_a_q <= src_a_data;
    last_b_q <= src_b_data;
  end

  assign src_a_data = instr_valid ? regs_q[instr_word[20:16]] : ~last_a_q;
  assign src_b_data = instr_valid ? regs_q[instr_word[15:11]] : ~last_b_q;
endmodule : gpr_file_model

// ==== verification/integer_add_unit_tb_top.sv ====
// self-checking bench for the integer add unit
`timescale 1ns/1ps
module integer_add_unit_tb_top;
  logic        clk_sys       = 1'b0;
  logic        reset         = 1'b1;
  logic        instr_valid   = 1'b0;
  logic [31:0] instr_word    = 32'h0000_0000;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] src_a_data, src_b_data, wb_data, avs_readdata, rd;
  logic [4:0]  wb_index;
  logic [3:0]  cond_field_zero, cr;
  logic        wb_valid, carry_flag, signed_wrap_flag, summary_flag, avs_waitrequest;
  logic        ca, ov, so;
  logic [31:0] ref_q [32];
  logic [8:0]  xo_tab [5] = '{9'h10A, 9'h00A, 9'h08A, 9'h0EA, 9'h0CA};
  int          miscompares, checks_done, n_exec;

  always #5 clk_sys = ~clk_sys;

  integer_add_unit i_dut (
    .clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .src_a_data(src_a_data), .src_b_data(src_b_data), .wb_valid(wb_valid),
    .wb_index(wb_index), .wb_data(wb_data), .carry_flag(carry_flag),
    .signed_wrap_flag(signed_wrap_flag), .summary_flag(summary_flag),
    .cond_field_zero(cond_field_zero), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  gpr_file_model i_gpr (
    .clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
    .src_a_data(src_a_data), .src_b_data(src_b_data));

  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: valid/flags got %b exp %b", $time, got, exp);
    end
  endtask : cmp_flags

  function automatic logic [31:0] mk_x(input logic [4:0] d, input logic [4:0] a,
                                       input logic [4:0] b, input logic oe,
                                       input logic [8:0] xo, input logic rc);
    return {6'h1F, d, a, b, oe, xo, rc};
  endfunction : mk_x

  function automatic logic [31:0] mk_d(input logic [5:0] opc, input logic [4:0] d,
                                       input logic [4:0] a, input logic [15:0] imm);
    return {opc, d, a, imm};
  endfunction : mk_d

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= adr;
    avs_writedata <= wd;
    // look at waitrequest mid-cycle, then complete at the next rising edge
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    @(posedge clk_sys);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0000_0000);
    cmp_data(rd, exp, "register read");
  endtask : rdchk

  // issue one word and judge write-back and flags against the reference
  task automatic exec(input logic [31:0] w, input logic en);
    logic [31:0] a, b;
    logic [32:0] s;
    logic [5:0]  opc;
    logic        cin, upd, oe, rc, wr;
    opc = w[31:26];
    a = ref_q[w[20:16]];
    b = ref_q[w[15:11]];
    cin = 1'b0;
    upd = 1'b1;
    oe = 1'b0;
    rc = 1'b0;
    if (opc == 6'h1F) begin
      oe = w[10];
      rc = w[0];
      case (w[9:1])
        9'h10A: upd = 1'b0;
        9'h08A: cin = ca;
        9'h0EA: begin cin = ca; b = 32'hFFFF_FFFF; end
        9'h0CA: begin cin = ca; b = 32'h0000_0000; end
        default: ;
      endcase
    end else begin
      b = opc == 6'h0F ? {w[15:0], 16'h0000} : {{16{w[15]}}, w[15:0]};
      rc = (opc == 6'h0D);
      upd = ~opc[1];
      if (opc[1] && w[20:16] == 5'h00) a = 32'h0000_0000;
    end
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    if (en) begin
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      wr = (a[31] == b[31]) && (s[31] != a[31]);
      if (upd) ca = s[32];
      if (oe) begin ov = wr; so = so | wr; end
      if (rc) cr = {s[31], ~s[31] && s[31:0] != 0, s[31:0] == 0, so};
      ref_q[w[25:21]] = s[31:0];
      n_exec++;
      cmp_data(wb_data, s[31:0], "sum");
      cmp_data({27'h0, wb_index}, {27'h0, w[25:21]}, "index");
    end
    cmp_flags({wb_valid, carry_flag, signed_wrap_flag, summary_flag, cond_field_zero},
              {en, ca, ov, so, cr});
  endtask : exec

  task automatic s_reset();
    rdchk(4'h0, 32'h0000_0000);
    rdchk(4'hC, 32'h0000_0001);
    rdchk(4'h4, 32'h0000_0000);
    rdchk(4'h2, 32'h0000_0000);
  endtask : s_reset

  task automatic s_imm();
    exec(mk_d(6'h0E, 5'd1, 5'd0, 16'hFFFB), 1'b1);
    exec(mk_d(6'h0E, 5'd0, 5'd1, 16'h0003), 1'b1);
    exec(mk_d(6'h0E, 5'd3, 5'd0, 16'h0001), 1'b1);
    exec(mk_d(6'h0F, 5'd2, 5'd0, 16'h1234), 1'b1);
    exec(mk_d(6'h0F, 5'd7, 5'd0, 16'h8000), 1'b1);
    exec(mk_d(6'h0F, 5'd6, 5'd1, 16'h0001), 1'b1);
    exec(mk_d(6'h0E, 5'd7, 5'd7, 16'hFFFF), 1'b1);
  endtask : s_imm

  task automatic s_carry();
    exec(mk_d(6'h0C, 5'd4, 5'd1, 16'h0005), 1'b1);
    exec(mk_d(6'h0D, 5'd5, 5'd1, 16'h0001), 1'b1);
    exec(mk_d(6'h0D, 5'd5, 5'd1, 16'h0005), 1'b1);
    exec(mk_d(6'h0D, 5'd5, 5'd7, 16'h0001), 1'b1);
  endtask : s_carry

  task automatic s_reg();
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 8; k++) begin
        exec(mk_x(5'd8, k[2] ? 5'd7 : 5'd1, k[2] ? 5'd7 : 5'd2, k[1], xo_tab[i], k[0]),
             1'b1);
      end
    end
    rdchk(4'h0, {29'h0, so, ov, ca});
  endtask : s_reg

  task automatic s_bus();
    bus(1'b1, 4'h0, 32'h0000_0000);
    ca = 1'b0;
    ov = 1'b0;
    so = 1'b0;
    rdchk(4'h0, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0001);
    ca = 1'b1;
    exec(mk_x(5'd9, 5'd1, 5'd2, 1'b0, 9'h08A, 1'b1), 1'b1);
    rdchk(4'h4, {28'h0, cr});
    bus(1'b1, 4'h4, 32'h0000_000F);
    rdchk(4'h4, {28'h0, cr});
    rdchk(4'h8, 32'(n_exec));
    bus(1'b1, 4'hC, 32'h0000_0000);
    exec(mk_d(6'h0E, 5'd10, 5'd0, 16'h0055), 1'b0);
    bus(1'b1, 4'hC, 32'h0000_0001);
    rdchk(4'hC, 32'h0000_0001);
    exec(mk_x(5'd11, 5'd7, 5'd0, 1'b1, 9'h0CA, 1'b0), 1'b1);
  endtask : s_bus

  initial begin
    for (int i = 0; i < 32; i++) ref_q[i] = 32'h0000_0000;
    {ca, ov, so, cr} = 7'h00;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    s_reset();
    s_imm();
    s_carry();
    s_reg();
    s_bus();
    end_of_test();
  end

  initial begin
    #500us;
    miscompares++;
    end_of_test();
  end
endmodule : integer_add_unit_tb_top
